// >>> hw/ssci_regs.svh
// Constants of the serial sensor command interface: command codes,
// field values and timing. Holds definitions only; included by name.
`ifndef SSCI_REGS_SVH
`define SSCI_REGS_SVH
`define SSCI_CMD_RESET    8'h1e
`define SSCI_CMD_ADC_READ 8'h00
`define SSCI_PROM_HI      4'ha
`define SSCI_CONV_HI      3'h2
`define SSCI_OSR_MAX      3'h4
`define SSCI_I2C_ADDR_HI  6'h3b
`define SSCI_PROM_WORDS   8
`define SSCI_WORD_BITS    16
`define SSCI_RESULT_BITS  24
`define SSCI_CLK_MHZ      25
`define SSCI_CONV_NS_256  600000
`define SSCI_CONV_CYC_256 (`SSCI_CONV_NS_256 * `SSCI_CLK_MHZ / 1000)
`endif

// >>> hw/ssci_pkg.sv
// Types and the command decoder of the serial sensor command interface.
// Assumes the constants header is on the include path.
package ssci_pkg;
`include "ssci_regs.svh"

	typedef enum logic [2:0] {
		K_NONE, K_RESET, K_CONV, K_ADC, K_PROM
	} ssci_kind_t;

	typedef enum logic [2:0] {
		I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RACK
	} ssci_i2c_st_t;

	typedef struct packed {
		ssci_kind_t kind;
		logic       temp;
		logic [2:0] oversampling_ratio;
		logic [2:0] idx;
	} ssci_cmd_t;

	typedef logic [`SSCI_WORD_BITS-1:0] ssci_word_t;
	typedef ssci_word_t [`SSCI_PROM_WORDS-1:0] ssci_prom_t;

	// Undefined bytes decode to K_NONE so that they do nothing.
	function automatic ssci_cmd_t ssci_decode(input logic [7:0] b);
		ssci_cmd_t c;
		c.kind = K_NONE;
		c.temp = b[4];
		c.oversampling_ratio  = b[3:1];
		c.idx  = b[3:1];
		if (b == `SSCI_CMD_RESET) begin
			c.kind = K_RESET;
		end else if (b == `SSCI_CMD_ADC_READ) begin
			c.kind = K_ADC;
		end else if (b[7:4] == `SSCI_PROM_HI && !b[0]) begin
			c.kind = K_PROM;
		end else if (b[7:5] == `SSCI_CONV_HI && !b[0] &&
				b[3:1] <= `SSCI_OSR_MAX) begin
			c.kind = K_CONV;
		end
		return c;
	endfunction
endpackage

// >>> hw/ssci_top.sv
// Command interpreter of a pressure/temperature sensor: SPI and I2C
// slave front ends, conversion sequencer, result store and PROM image.
// Assumes the SPI clock runs only for framed traffic and that the
// front end presents converted samples on the mclk side.
`timescale 1ns/100ps
`default_nettype none
`include "ssci_regs.svh"

module ssci_top #(
	parameter int         CONV_CYC_256 = `SSCI_CONV_CYC_256,
	parameter ssci_pkg::ssci_prom_t PROM_INIT = {8{16'h5a5a}}
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire logic                        protocol_select_pin,
	input  wire logic                        chip_select_pin,
	input  wire logic                        spi_sclk,
	input  wire logic                        spi_sdi,
	output var  logic                        spi_sdo,
	output var  logic                        spi_sdo_oe,
	input  wire logic                        i2c_scl,
	input  wire logic                        i2c_sda_i,
	output var  logic                        i2c_sda_o,
	output var  logic                        i2c_sda_oe,
	input  wire logic [`SSCI_RESULT_BITS-1:0] adc_pressure,
	input  wire logic [`SSCI_RESULT_BITS-1:0] adc_temperature,
	output var  logic                        conv_busy,
	output var  logic                        conv_temp,
	output var  logic                        result_valid
);
	import ssci_pkg::*;

	logic [3:0]  sy1_r, sy2_r;        // {ps, csb, scl, sda}
	logic [1:0]  pin_prev_r;          // {scl, sda} one cycle older
	logic [2:0]  tg_r;                // SPI command toggle sync
	logic        spi_ev;
	logic        i2c_mode, scl_rise, scl_fall, i2c_start, i2c_stop;
	logic        i2c_cmd_v_r;
	logic [7:0]  i2c_sh_r;
	logic [3:0]  i2c_bcnt_r;
	logic        i2c_rw_r;
	logic [23:0] i2c_tx_r, resp_r;
	ssci_i2c_st_t i2c_st_r;
	ssci_cmd_t   cmd;
	logic        cmd_v;
	ssci_prom_t  prom_r;
	logic [19:0] conv_cnt_r;
	logic        corrupt_r;
	logic [23:0] result_r;
	logic        lrst_b;
	logic [3:0]  l_cnt_r;
	logic [7:0]  l_rx_r, l_byte_r;
	logic [23:0] l_tx_r;
	logic        l_tgl_r;
	logic [4:0]  l_oidx_r;
	ssci_cmd_t   l_cmd;

	// ---- SPI link domain, clocked by spi_sclk ----
	// Deselect or I2C mode holds the link in reset, so stray clocks
	// and data while deselected are ignored and the output lets go.
	assign lrst_b = rst_b & ~chip_select_pin & ~protocol_select_pin;
	assign l_cmd  = ssci_decode({l_rx_r[6:0], spi_sdi});

	// Input side samples on rising edges, valid for mode 0 and mode 3.
	// The answer word is picked from core registers that only change on
	// commands or when a conversion ends, so they stand still while this byte is clocked in unless a run ends then.
	always_ff @(posedge spi_sclk or negedge lrst_b) begin
		if (!lrst_b) begin
			l_cnt_r <= 4'h0;
			l_rx_r  <= 8'h00;
			l_tx_r  <= 24'h000000;
		end else begin
			if (l_cnt_r != 4'h8) begin
				l_cnt_r <= l_cnt_r + 4'h1;
				l_rx_r  <= {l_rx_r[6:0], spi_sdi};
			end
			if (l_cnt_r == 4'h7) begin
				if (l_cmd.kind == K_ADC && result_valid) begin
					l_tx_r <= result_r;
				end else if (l_cmd.kind == K_PROM) begin
					l_tx_r <= {prom_r[l_cmd.idx], 8'h00};
				end else begin
					l_tx_r <= 24'h000000;
				end
			end
		end
	end

	// Command byte handed to the core by a toggle; the byte stays
	// put until the next frame, long after the core has taken it.
	always_ff @(posedge spi_sclk or negedge rst_b) begin
		if (!rst_b) begin
			l_tgl_r  <= 1'b0;
			l_byte_r <= 8'h00;
		end else if (lrst_b && l_cnt_r == 4'h7) begin
			l_tgl_r  <= ~l_tgl_r;
			l_byte_r <= {l_rx_r[6:0], spi_sdi};
		end
	end

	// Output side changes on falling edges, MSB first; the first
	// falling edge of mode 3 comes before any bit and is ignored.
	always_ff @(negedge spi_sclk or negedge lrst_b) begin
		if (!lrst_b) begin
			l_oidx_r   <= 5'h00;
			spi_sdo    <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else if (l_cnt_r == 4'h8) begin
			spi_sdo_oe <= 1'b1;
			if (l_oidx_r < 5'd24) begin
				spi_sdo  <= l_tx_r[5'd23 - l_oidx_r];
				l_oidx_r <= l_oidx_r + 5'h01;
			end else begin
				spi_sdo <= 1'b0;
			end
		end
	end

	// ---- Core domain, clocked by mclk ----
	// Pin synchronisers; only the second stage is looked at.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sy1_r      <= 4'hf;
			sy2_r      <= 4'hf;
			pin_prev_r <= 2'h3;
			tg_r       <= 3'h0;
		end else begin
			sy1_r      <= {protocol_select_pin, chip_select_pin,
				i2c_scl, i2c_sda_i};
			sy2_r      <= sy1_r;
			pin_prev_r <= sy2_r[1:0];
			tg_r       <= {tg_r[1:0], l_tgl_r};
		end
	end

	assign spi_ev    = tg_r[2] ^ tg_r[1];
	assign i2c_mode  = sy2_r[3];
	assign scl_rise  = sy2_r[1] & ~pin_prev_r[1];
	assign scl_fall  = ~sy2_r[1] & pin_prev_r[1];
	assign i2c_start = sy2_r[1] & pin_prev_r[1] & ~sy2_r[0] & pin_prev_r[0];
	assign i2c_stop  = sy2_r[1] & pin_prev_r[1] & sy2_r[0] & ~pin_prev_r[0];
	assign cmd_v     = spi_ev | i2c_cmd_v_r;
	assign cmd       = ssci_decode(spi_ev ? l_byte_r : i2c_sh_r);

	// PROM image: empty until a reset command copies it in; word 7
	// carries the CRC nibble that the host checks.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prom_r <= '0;
		end else if (cmd_v && cmd.kind == K_RESET) begin
			prom_r <= PROM_INIT;
		end
	end

	// Conversion sequencer. A second start or a read while busy does
	// not stop the run; before the last busy cycle it only marks the outcome as spoiled.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			conv_busy  <= 1'b0;
			conv_temp  <= 1'b0;
			conv_cnt_r <= 20'h00000;
			corrupt_r  <= 1'b0;
		end else if (cmd_v && cmd.kind == K_RESET) begin
			conv_busy  <= 1'b0;
			corrupt_r  <= 1'b0;
			conv_cnt_r <= 20'h00000;
		end else if (cmd_v && cmd.kind == K_CONV && !conv_busy) begin
			conv_busy  <= 1'b1;
			conv_temp  <= cmd.temp;
			conv_cnt_r <= 20'(CONV_CYC_256 << cmd.oversampling_ratio);
			corrupt_r  <= 1'b0;
		end else if (conv_busy) begin
			if (cmd_v && (cmd.kind == K_CONV || cmd.kind == K_ADC)) begin
				corrupt_r <= 1'b1;
			end
			if (conv_cnt_r == 20'h00001) begin
				conv_busy <= 1'b0;
			end
			conv_cnt_r <= conv_cnt_r - 20'h00001;
		end
	end

	// Result store: valid after a clean or spoiled finish, cleared by
	// a read so that a repeat returns zero. A finish wins over a read,
	// but a reset command wins over both so the state is always known.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			result_r     <= 24'h000000;
			result_valid <= 1'b0;
		end else if (cmd_v && cmd.kind == K_RESET) begin
			result_valid <= 1'b0;
		end else if (conv_busy && conv_cnt_r == 20'h00001) begin
			result_r     <= (conv_temp ? adc_temperature : adc_pressure)
				^ {24{corrupt_r}};
			result_valid <= 1'b1;
		end else if (cmd_v && cmd.kind != K_NONE && cmd.kind != K_PROM) begin
			result_valid <= 1'b0;
		end
	end

	// Word prepared for the next I2C read transaction.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			resp_r <= 24'h000000;
		end else if (cmd_v && cmd.kind == K_ADC) begin
			resp_r <= result_valid ? result_r : 24'h000000;
		end else if (cmd_v && cmd.kind == K_PROM) begin
			resp_r <= {prom_r[cmd.idx], 8'h00};
		end
	end

	// I2C slave. Only pulls SDA low; release lets the bus float high.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			i2c_st_r    <= I_IDLE;
			i2c_bcnt_r  <= 4'h0;
			i2c_sh_r    <= 8'h00;
			i2c_rw_r    <= 1'b0;
			i2c_tx_r    <= 24'h000000;
			i2c_sda_oe  <= 1'b0;
			i2c_sda_o   <= 1'b0;
			i2c_cmd_v_r <= 1'b0;
		end else begin
			i2c_cmd_v_r <= 1'b0;
			if (!i2c_mode || i2c_stop) begin
				i2c_st_r   <= I_IDLE;
				i2c_sda_oe <= 1'b0;
			end else if (i2c_start) begin
				i2c_st_r   <= I_ADDR;
				i2c_bcnt_r <= 4'h0;
				i2c_sda_oe <= 1'b0;
			end else begin
				case (i2c_st_r)
				I_ADDR, I_WR: begin
					if (scl_rise) begin
						i2c_sh_r   <= {i2c_sh_r[6:0], sy2_r[0]};
						i2c_bcnt_r <= i2c_bcnt_r + 4'h1;
					end else if (scl_fall && i2c_bcnt_r == 4'h8) begin
						if (i2c_st_r == I_WR) begin
							i2c_sda_oe  <= 1'b1;
							i2c_cmd_v_r <= 1'b1;
							i2c_rw_r    <= 1'b0;
							i2c_st_r    <= I_ACK;
						end else if (i2c_sh_r[7:1] ==
								{`SSCI_I2C_ADDR_HI, ~sy2_r[2]}) begin
							i2c_sda_oe <= 1'b1;
							i2c_rw_r   <= i2c_sh_r[0];
							i2c_tx_r   <= resp_r;
							i2c_st_r   <= I_ACK;
						end else begin
							i2c_st_r <= I_IDLE;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						i2c_bcnt_r <= 4'h0;
						if (i2c_rw_r) begin
							i2c_sda_oe <= ~i2c_tx_r[23];
							i2c_tx_r   <= {i2c_tx_r[22:0], 1'b0};
							i2c_st_r   <= I_RD;
						end else begin
							i2c_sda_oe <= 1'b0;
							i2c_st_r   <= I_WR;
						end
					end
				end
				I_RD: begin
					if (scl_rise) begin
						i2c_bcnt_r <= i2c_bcnt_r + 4'h1;
					end else if (scl_fall && i2c_bcnt_r == 4'h8) begin
						i2c_sda_oe <= 1'b0;
						i2c_st_r   <= I_RACK;
					end else if (scl_fall) begin
						i2c_sda_oe <= ~i2c_tx_r[23];
						i2c_tx_r   <= {i2c_tx_r[22:0], 1'b0};
					end
				end
				I_RACK: begin
					if (scl_rise && sy2_r[0]) begin
						i2c_st_r <= I_IDLE;
					end else if (scl_fall) begin
						i2c_bcnt_r <= 4'h0;
						i2c_sda_oe <= ~i2c_tx_r[23];
						i2c_tx_r   <= {i2c_tx_r[22:0], 1'b0};
						i2c_st_r   <= I_RD;
					end
				end
				default: i2c_st_r <= I_IDLE;
				endcase
			end
		end
	end

	// Checks on the core domain.
	conv_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_CONV && !conv_busy |=> conv_busy ##0
		conv_temp == $past(cmd.temp)) else $error("start lost");
	busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		conv_busy && conv_cnt_r > 20'h00001 && !(cmd_v && cmd.kind == K_RESET)
		|=> conv_busy && !$rose(result_valid)) else $error("early end");
	read_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_ADC && !(conv_busy && conv_cnt_r == 20'h00001)
		|=> !result_valid) else $error("valid kept");
	busy_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
		i2c_cmd_v_r && cmd.kind == K_ADC && conv_busy |=> resp_r == 24'h0)
		else $error("busy read nonzero");
	spoil_mark_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_CONV && conv_busy && conv_cnt_r > 20'h00001
		|=> corrupt_r && conv_busy) else $error("spoil lost");
	reset_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_RESET |=> prom_r == PROM_INIT && !conv_busy
		&& !result_valid) else $error("reset incomplete");
	prom_word_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_PROM |=> resp_r[23:8] ==
		$past(prom_r[cmd.idx])) else $error("prom word wrong");
	addr_ack_a: assert property (@(posedge mclk) disable iff (!rst_b)
		i2c_mode && !i2c_stop && !i2c_start && i2c_st_r == I_ADDR && scl_fall
		&& i2c_bcnt_r == 4'h8 && i2c_sh_r[7:1] == {`SSCI_I2C_ADDR_HI,
		~sy2_r[2]} |=> i2c_sda_oe && i2c_st_r == I_ACK)
		else $error("address not acked");
	deselect_a: assert property (@(posedge mclk) disable iff (!rst_b)
		chip_select_pin || protocol_select_pin |-> !spi_sdo_oe)
		else $error("sdo driven");
	idle_cmd_a: assert property (@(posedge mclk) disable iff (!rst_b)
		cmd_v && cmd.kind == K_NONE && !conv_busy |=> $stable(result_r) &&
		!conv_busy) else $error("undefined byte acted");

	conv_done_c: cover property (@(posedge mclk) disable iff (!rst_b)
		$fell(conv_busy) ##1 result_valid);
	i2c_read_c: cover property (@(posedge mclk) disable iff (!rst_b)
		i2c_st_r == I_RACK && scl_fall);
	spi_cmd_c: cover property (@(posedge mclk) disable iff (!rst_b)
		spi_ev && cmd.kind == K_PROM);

endmodule // ssci_top
`default_nettype wire

// >>> verif/ssci_host_model.sv
// SPI host model that frames one command per chip-select frame.
// Assumes the testbench calls xfer from its main sequence.
`timescale 1ns/100ps
`default_nettype none

module ssci_host_model (
	output var  logic chip_select_pin,
	output var  logic spi_sclk,
	output var  logic spi_sdi,
	input  wire logic spi_sdo,
	input  wire logic spi_sdo_oe
);
	// Idle bus: deselected, clock parked low.
	initial begin
		chip_select_pin = 1'b1;
		spi_sclk        = 1'b0;
		spi_sdi         = 1'b0;
	end

	// Eight command bits, then nrd answer bits taken at rising edges.
	// With other set the frame belongs to another slave and our select
	// stays high. Between frames the clock only moves to the next mode's idle level.
	task automatic xfer(input logic [7:0] cmd, input int nrd,
			input bit mode3, input bit other,
			output logic [23:0] rd, output bit oe_bad);
		rd = 24'h0;
		oe_bad = 1'b0;
		spi_sclk = mode3;
		#3;
		chip_select_pin = other;
		#3;
		for (int i = 0; i < 8 + nrd; i++) begin
			spi_sclk = 1'b0;
			spi_sdi = (i < 8) ? cmd[7 - i] : ~spi_sdi;
			#3;
			if (i >= 8) begin
				rd = {rd[22:0], spi_sdo};
				if (spi_sdo_oe !== !other)
					oe_bad = 1'b1;
			end
			spi_sclk = 1'b1;
			#3;
		end
		spi_sclk = mode3;
		#3;
		chip_select_pin = 1'b1;
		spi_sdi = ~spi_sdi;
	endtask
endmodule // ssci_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the sensor command interface, SPI side.
// Assumes the package, the design top and the host model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "ssci_regs.svh"

module testbench;
	import ssci_pkg::*;
	localparam int CONV_CYC = 20;
	localparam ssci_prom_t PROM_V = {16'hc3e7, 16'h6b01, 16'h2d94,
		16'h8f5a, 16'h17c6, 16'h4e2b, 16'hb870, 16'h9135};
	logic        mclk, rst_b, chip_select_pin, spi_sclk, spi_sdi;
	logic        spi_sdo, spi_sdo_oe, i2c_sda_o, i2c_sda_oe;
	logic        conv_busy, conv_temp, result_valid, mode3;
	logic [23:0] adc_pressure, adc_temperature, rd, m_res;
	logic [23:0] lfsr_r = 24'h010e83;
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;
	int          busy_len, m_valid;

	ssci_top #(.CONV_CYC_256(CONV_CYC), .PROM_INIT(PROM_V)) u_ssci_top (
		.mclk(mclk), .rst_b(rst_b), .protocol_select_pin(1'b0),
		.chip_select_pin(chip_select_pin), .spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.i2c_scl(1'b1), .i2c_sda_i(1'b1), .i2c_sda_o(i2c_sda_o),
		.i2c_sda_oe(i2c_sda_oe), .adc_pressure(adc_pressure),
		.adc_temperature(adc_temperature), .conv_busy(conv_busy),
		.conv_temp(conv_temp), .result_valid(result_valid));

	ssci_host_model u_ssci_host_model (
		.chip_select_pin(chip_select_pin), .spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

	// Core clock and a watchdog so a hung handshake still ends the run.
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		busy_len += (conv_busy === 1'b1);
		if (cycles == 30000) begin
			miscompares++;
			$display("BAD %0t watchdog expired", $time);
			wrap_up();
		end
	end

	function automatic logic [23:0] lfsr_nxt(input logic [23:0] x);
		return {x[22:0], x[23] ^ x[22] ^ x[21] ^ x[16]};
	endfunction

	// Compares and counts; an unknown bit matches only an unknown bit.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
			input string msg);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One frame, alternating SPI modes, then the spacing the core needs.
	task automatic send(input logic [7:0] c, input int nrd, input bit oth);
		bit bad;
		@(negedge mclk);
		u_ssci_host_model.xfer(c, nrd, mode3, oth, rd, bad);
		mode3 = ~mode3;
		chk({23'h0, bad}, 24'h0, "output enable");
		repeat (6) @(negedge mclk);
	endtask

	// A conversion with traffic to another slave while busy and an undefined byte,
	// still while busy, at ratio 0 in its last busy cycle; at ratio 4 a mid-conversion read spoils the result.
	task automatic conv(input logic [7:0] c);
		logic [23:0] smp;
		int n;
		lfsr_r = lfsr_nxt(lfsr_r);
		@(negedge mclk);
		adc_pressure = lfsr_r;
		adc_temperature = ~lfsr_r;
		smp = c[4] ? ~lfsr_r : lfsr_r;
		busy_len = 0;
		send(c, 0, 1'b0);
		chk({23'h0, conv_temp}, {23'h0, c[4]}, "conv kind");
		send(8'h1e, 24, 1'b1);
		if (c[3]) begin
			send(8'h00, 24, 1'b0);
			chk(rd, 24'h0, "read while busy");
			if (c[4])
				send(c, 0, 1'b0);
			smp = smp ^ 24'hffffff;
		end
		send(8'h01, 0, 1'b0);
		n = 0;
		while (conv_busy === 1'b1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		chk(24'(busy_len), 24'(CONV_CYC << c[3:1]), "conv time");
		m_valid = 1;
		m_res = smp;
		chk({23'h0, result_valid}, 24'(m_valid), "valid");
		send(8'h00, 24, 1'b0);
		chk(rd, m_valid ? m_res : 24'h0, "result");
		m_valid = 0;
		send(8'h00, 24, 1'b0);
		chk(rd, 24'h0, "repeat read");
		chk({23'h0, result_valid}, 24'(m_valid), "valid cleared");
	endtask

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: power-on, unloaded image, reset, PROM, conversions.
	initial begin
		rst_b = 1'b0;
		adc_pressure = 24'h0;
		adc_temperature = 24'h0;
		mode3 = 1'b0;
		m_valid = 0;
		busy_len = 0;
		repeat (5) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		send(8'h00, 24, 1'b0);
		chk(rd, 24'h0, "read without conversion");
		send(8'ha6, 16, 1'b0);
		chk(rd, 24'h0, "image before reset");
		send(8'h1e, 0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			send(8'ha0 | 8'(i << 1), 16, 1'b0);
			chk(rd, {8'h0, PROM_V[i]}, "prom word");
		end
		for (int k = 0; k < 10; k++)
			conv(8'(8'h40 + (k / 5) * 16 + (k % 5) * 2));
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
